// File: rtl/wsid_decoder.sv
/*
  Weight stream index decoder: parses chunks of quotients and pipelined
  remainders for one slice, maps indices to signed weights and emits
  weights and zero runs. Assumes the slice header is parsed outside and
  handed in on slice_start_i, and the palette is written beforehand.
*/
`timescale 1ns/1ns
`include "wsid_map.svh"

// Overview of operation
// - Each weight index is an unsigned 9-bit value, 0 to 511.
// - Index below table entry count selects stored table entry.
// - Otherwise coded weight is index minus entry count plus direct offset.
// - Coded weight is sign-magnitude: bit 0 negative, magnitude is value shifted right.
// - Rice index is quotient shifted by exponent ORed with remainder bits.
// - Untruncated quotient is a run of ones ended by one zero.
// - Truncated quotient: 0 is zero, 10 is one, 11 is two.
// - Uncompressed width is ceil(log2(entry count)), or precision when table empty.
// - Alternating zero-run mode is on when run exponent is below 4.
// - Alternating output: leading run on reload, then weight and run alternately.
// - Slice has count weights and count runs, plus one on reload.
// - Runs are Rice coded with unbounded unary quotient.
// - A chunk holds 0 to 12 indices and 0 to 12 runs.
// - Balance 8 or more: runs only; below 0: indices only; else both.
// - Remainders of one chunk's quotients come in the next chunk.
// - Chunks continue until expected counts and pending remainders are done.
// - Weight divisor 0 to 5 is a Rice exponent, 7 means uncompressed.
// - Run exponent 6 disables zero-run coding for the slice.
// - Without reload, offset, count, precision and table entries are kept.
module wsid_decoder
  import wsid_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  // Slice header
  input  wire logic        slice_start_i,
  output logic             slice_ready_o,
  input  wire logic [14:0] slicelen_i,
  input  wire logic [2:0]  wdiv_i,
  input  wire logic        wtrunc_i,
  input  wire logic        newpal_i,
  input  wire logic [2:0]  zdiv_i,
  input  wire logic [4:0]  dirofs_i,
  input  wire logic [4:0]  palsize_i,
  input  wire logic [2:0]  palbits_i,
  // Palette load
  input  wire logic        pal_wr_i,
  input  wire logic [4:0]  pal_addr_i,
  input  wire logic [8:0]  pal_data_i,
  // Bit stream
  input  wire logic        bit_i,
  input  wire logic        bit_valid_i,
  output logic             bit_ready_o,
  // Decoded items
  output logic             out_valid_o,
  input  wire logic        out_ready_i,
  output logic             out_is_run_o,
  output logic [15:0]      out_value_o
);

  wsid_state_e  st_reg;
  logic [15:0]  wcnt_reg;
  logic [15:0]  zcnt_reg;
  logic [2:0]   wdiv_reg;
  logic         wtrunc_reg;
  logic [2:0]   zdiv_reg;
  logic [4:0]   dirofs_reg;
  logic [5:0]   psize_reg;
  logic [3:0]   pbits_reg;
  logic [15:0]  wq_i_reg;
  logic [15:0]  zq_i_reg;
  logic [3:0]   chunk_n_reg;
  logic [15:0]  q_reg;
  logic         w_en_reg;
  logic         z_en_reg;
  logic [4:0]   w_wr_reg;
  logic [4:0]   w_rd_reg;
  logic [4:0]   w_mark_reg;
  logic [4:0]   z_wr_reg;
  logic [4:0]   z_rd_reg;
  logic [4:0]   z_mark_reg;
  logic         kind_run_reg;
  logic         expect_run_reg;
  logic [3:0]   rem_left_reg;
  logic [15:0]  acc_reg;
  logic [16:0]  val_reg;

  logic         alt_w;
  logic         unc_w;
  logic [3:0]   ubits_w;
  logic [3:0]   rbits_w;
  logic [3:0]   w_lim_w;
  logic signed [16:0] balance_w;
  logic         w_go_w;
  logic         z_go_w;
  logic         bit_take_w;
  logic         w_done_w;
  logic [4:0]   w_qval_w;
  logic         z_done_w;
  logic         w_pend_w;
  logic         z_pend_w;
  logic         pick_run_w;
  logic [4:0]   wq_rdata_w;
  logic [15:0]  zq_rdata_w;
  logic [8:0]   pal_rdata_w;
  logic [8:0]   idx_w;
  logic         pal_hit_w;
  logic [9:0]   tmp_w;
  logic [15:0]  wval_w;
  logic         fifo_in_ready_w;
  logic         fifo_push_w;
  logic [16:0]  fifo_out_w;

  function automatic logic [3:0] ceil_log2(input logic [5:0] n);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < 6; i++)
    begin
      if ((6'h1 << i) < n)
      begin
        r = 4'(i + 1);
      end
    end
    return r;
  endfunction

  assign alt_w    = (zdiv_reg < `WSID_ALT_LIMIT);
  assign unc_w    = (wdiv_reg == `WSID_WDIV_UNC);
  assign ubits_w  = (psize_reg != 6'h0) ? ceil_log2(psize_reg) : pbits_reg;
  assign rbits_w  = unc_w ? ubits_w : {1'b0, wdiv_reg};
  assign w_lim_w  = (unc_w && ubits_w > `WSID_UNC_NARROW) ? `WSID_PER_CHUNK_WIDE
                                                          : `WSID_PER_CHUNK;
  assign balance_w = $signed({1'b0, wq_i_reg}) - $signed({1'b0, zq_i_reg});

  // Per-phase gating from the flags latched at chunk start
  assign w_go_w = (st_reg == ST_WQ) && w_en_reg && (chunk_n_reg < w_lim_w)
                  && (wq_i_reg < wcnt_reg);
  assign z_go_w = (st_reg == ST_ZQ) && z_en_reg && (chunk_n_reg < `WSID_PER_CHUNK)
                  && (zq_i_reg < zcnt_reg);

  assign bit_ready_o = (w_go_w && !unc_w) || z_go_w
                       || ((st_reg == ST_REM_BITS) && (rem_left_reg != 4'h0));
  assign bit_take_w  = bit_ready_o && bit_valid_i;

  // Index quotient complete: a zero, or the second one when truncated
  assign w_done_w = w_go_w && (unc_w || (bit_take_w && (!bit_i
                    || (wtrunc_reg && q_reg[4:0] == `WSID_TRUNC_MAX - 5'h1))));
  assign w_qval_w = (unc_w || !bit_i) ? q_reg[4:0] : q_reg[4:0] + 5'h1;
  assign z_done_w = z_go_w && bit_take_w && !bit_i;

  assign w_pend_w   = (w_rd_reg != w_mark_reg);
  assign z_pend_w   = (z_rd_reg != z_mark_reg);
  assign pick_run_w = z_pend_w && (expect_run_reg || !w_pend_w);

  // Index mapping through the table or directly
  assign idx_w     = acc_reg[8:0];
  assign pal_hit_w = ({3'h0, psize_reg} > idx_w);
  assign tmp_w     = pal_hit_w ? {1'b0, pal_rdata_w}
                               : {1'b0, idx_w} - {4'h0, psize_reg} + {5'h0, dirofs_reg};
  assign wval_w    = tmp_w[0] ? -{7'h0, tmp_w[9:1]} : {7'h0, tmp_w[9:1]};

  assign fifo_push_w   = (st_reg == ST_OUT);
  assign slice_ready_o = (st_reg == ST_IDLE);
  assign out_is_run_o  = fifo_out_w[16];
  assign out_value_o   = fifo_out_w[15:0];

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      st_reg         <= ST_IDLE;
      wcnt_reg       <= 16'h0;
      zcnt_reg       <= 16'h0;
      wdiv_reg       <= 3'h0;
      wtrunc_reg     <= 1'b0;
      zdiv_reg       <= `WSID_ZDIV_OFF;
      dirofs_reg     <= 5'h0;
      psize_reg      <= 6'h0;
      pbits_reg      <= `WSID_PBITS_BIAS;
      wq_i_reg       <= 16'h0;
      zq_i_reg       <= 16'h0;
      chunk_n_reg    <= 4'h0;
      q_reg          <= 16'h0;
      w_en_reg       <= 1'b0;
      z_en_reg       <= 1'b0;
      w_wr_reg       <= 5'h0;
      w_rd_reg       <= 5'h0;
      w_mark_reg     <= 5'h0;
      z_wr_reg       <= 5'h0;
      z_rd_reg       <= 5'h0;
      z_mark_reg     <= 5'h0;
      kind_run_reg   <= 1'b0;
      expect_run_reg <= 1'b0;
      rem_left_reg   <= 4'h0;
      acc_reg        <= 16'h0;
      val_reg        <= 17'h0;
    end
    else
    begin
      unique case (st_reg)
        ST_IDLE:
        begin
          if (slice_start_i)
          begin
            wcnt_reg   <= {1'b0, slicelen_i} + 16'h1;
            zcnt_reg   <= {1'b0, slicelen_i} + 16'h1 + {15'h0, newpal_i};
            wdiv_reg   <= wdiv_i;
            wtrunc_reg <= wtrunc_i;
            zdiv_reg   <= zdiv_i;
            wq_i_reg   <= 16'h0;
            zq_i_reg   <= 16'h0;
            // Table parameters only reload with a new table
            if (newpal_i)
            begin
              dirofs_reg     <= dirofs_i;
              psize_reg      <= (palsize_i == 5'h0) ? 6'h0 : {1'b0, palsize_i} + 6'h1;
              pbits_reg      <= {1'b0, palbits_i} + `WSID_PBITS_BIAS;
              expect_run_reg <= (zdiv_i < `WSID_ALT_LIMIT);
            end
            st_reg <= ST_CHUNK;
          end
        end
        ST_CHUNK:
        begin
          w_en_reg    <= (balance_w < `WSID_BAL_HI || !alt_w) && (wq_i_reg < wcnt_reg);
          z_en_reg    <= (balance_w >= `WSID_BAL_LO) && alt_w && (zq_i_reg < zcnt_reg);
          w_mark_reg  <= w_wr_reg;
          z_mark_reg  <= z_wr_reg;
          chunk_n_reg <= 4'h0;
          q_reg       <= 16'h0;
          // Slice ends only when nothing is left to parse or finish
          if (wq_i_reg == wcnt_reg && (zq_i_reg == zcnt_reg || !alt_w)
              && w_wr_reg == w_rd_reg && z_wr_reg == z_rd_reg)
          begin
            st_reg <= ST_IDLE;
          end
          else
          begin
            st_reg <= ST_WQ;
          end
        end
        ST_WQ:
        begin
          if (!w_go_w)
          begin
            chunk_n_reg <= 4'h0;
            q_reg       <= 16'h0;
            st_reg      <= ST_ZQ;
          end
          else if (w_done_w)
          begin
            w_wr_reg    <= w_wr_reg + 5'h1;
            wq_i_reg    <= wq_i_reg + 16'h1;
            chunk_n_reg <= chunk_n_reg + 4'h1;
            q_reg       <= 16'h0;
          end
          else if (bit_take_w)
          begin
            q_reg <= q_reg + 16'h1;
          end
        end
        ST_ZQ:
        begin
          if (!z_go_w)
          begin
            st_reg <= ST_REM_SEL;
          end
          else if (z_done_w)
          begin
            z_wr_reg    <= z_wr_reg + 5'h1;
            zq_i_reg    <= zq_i_reg + 16'h1;
            chunk_n_reg <= chunk_n_reg + 4'h1;
            q_reg       <= 16'h0;
          end
          else if (bit_take_w)
          begin
            q_reg <= q_reg + 16'h1;
          end
        end
        ST_REM_SEL:
        begin
          if (!w_pend_w && !z_pend_w)
          begin
            st_reg <= ST_CHUNK;
          end
          else
          begin
            kind_run_reg <= pick_run_w;
            st_reg       <= ST_REM_FETCH;
          end
        end
        ST_REM_FETCH:
        begin
          if (kind_run_reg)
          begin
            acc_reg      <= zq_rdata_w;
            rem_left_reg <= {1'b0, zdiv_reg};
            z_rd_reg     <= z_rd_reg + 5'h1;
          end
          else
          begin
            acc_reg      <= {11'h0, wq_rdata_w};
            rem_left_reg <= rbits_w;
            w_rd_reg     <= w_rd_reg + 5'h1;
          end
          st_reg <= ST_REM_BITS;
        end
        ST_REM_BITS:
        begin
          if (rem_left_reg == 4'h0)
          begin
            if (kind_run_reg)
            begin
              val_reg        <= {1'b1, acc_reg};
              expect_run_reg <= 1'b0;
              st_reg         <= ST_OUT;
            end
            else
            begin
              st_reg <= ST_MAP_WAIT;
            end
          end
          else if (bit_take_w)
          begin
            acc_reg      <= {acc_reg[14:0], bit_i};
            rem_left_reg <= rem_left_reg - 4'h1;
          end
        end
        ST_MAP_WAIT:
        begin
          val_reg        <= {1'b0, wval_w};
          expect_run_reg <= alt_w;
          st_reg         <= ST_OUT;
        end
        ST_OUT:
        begin
          // Full FIFO holds the decoder here and so stops bit intake
          if (fifo_in_ready_w)
          begin
            st_reg <= ST_REM_SEL;
          end
        end
      endcase
    end
  end

  wsid_mem #(.W(`WSID_WQ_W), .D(`WSID_Q_DEPTH), .AW(`WSID_Q_AW)) u_wq_mem (
    .core_clk_i (core_clk_i),
    .we_i       (w_done_w),
    .waddr_i    (w_wr_reg),
    .wdata_i    (w_qval_w),
    .raddr_i    (w_rd_reg),
    .rdata_o    (wq_rdata_w)
  );

  wsid_mem #(.W(`WSID_ZQ_W), .D(`WSID_Q_DEPTH), .AW(`WSID_Q_AW)) u_zq_mem (
    .core_clk_i (core_clk_i),
    .we_i       (z_done_w),
    .waddr_i    (z_wr_reg),
    .wdata_i    (q_reg),
    .raddr_i    (z_rd_reg),
    .rdata_o    (zq_rdata_w)
  );

  wsid_mem #(.W(`WSID_IDX_W), .D(`WSID_PAL_DEPTH), .AW(`WSID_Q_AW)) u_pal_mem (
    .core_clk_i (core_clk_i),
    .we_i       (pal_wr_i),
    .waddr_i    (pal_addr_i),
    .wdata_i    (pal_data_i),
    .raddr_i    (idx_w[4:0]),
    .rdata_o    (pal_rdata_w)
  );

  wsid_fifo #(.W(`WSID_ITEM_W), .D(`WSID_FIFO_DEPTH)) u_out_fifo (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (fifo_push_w),
    .in_ready_o  (fifo_in_ready_w),
    .in_data_i   (val_reg),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (fifo_out_w)
  );

  trunc_quotient_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (w_done_w && wtrunc_reg && !unc_w) |-> (w_qval_w <= `WSID_TRUNC_MAX))
    else $error("truncated quotient above two");

  run_only_alt_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (fifo_push_w && val_reg[16]) |-> (zdiv_reg < `WSID_ALT_LIMIT))
    else $error("zero run emitted outside alternating mode");

  balance_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_reg == ST_CHUNK && alt_w && balance_w >= `WSID_BAL_HI) |=> !w_en_reg)
    else $error("indices enabled with balance of eight or more");

  chunk_limit_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_reg == ST_WQ || st_reg == ST_ZQ) |-> (chunk_n_reg <= `WSID_PER_CHUNK))
    else $error("more than twelve values in one chunk");

  output_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_value_o)))
    else $error("output changed while stalled");

  weight_count_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_reg != ST_IDLE) |-> (wq_i_reg <= wcnt_reg && zq_i_reg <= zcnt_reg))
    else $error("more values parsed than the slice holds");

  chunk_mark_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_reg == ST_CHUNK) |=> (w_mark_reg == $past(w_wr_reg) && z_mark_reg == $past(z_wr_reg)))
    else $error("pending quotient mark not taken at chunk start");

  sign_map_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (st_reg == ST_MAP_WAIT) |=> (val_reg[15] == ($past(tmp_w[0]) && $past(tmp_w[9:1]) != 9'h0)))
    else $error("weight sign does not follow coded bit 0");

endmodule // wsid_decoder

// File: rtl/wsid_map.svh
/*
  Constants of the weight stream index decoder: field limits, chunk
  sizes and queue depths. Assumes inclusion by the decoder's files only.
*/
`ifndef WSID_MAP_SVH
`define WSID_MAP_SVH

`define WSID_IDX_W          9
`define WSID_Q_DEPTH        32
`define WSID_Q_AW           5
`define WSID_PAL_DEPTH      32
`define WSID_FIFO_DEPTH     4
`define WSID_ITEM_W         17
`define WSID_WQ_W           5
`define WSID_ZQ_W           16
`define WSID_PER_CHUNK      4'hc
`define WSID_PER_CHUNK_WIDE 4'h8
`define WSID_UNC_NARROW     4'h5
`define WSID_ALT_LIMIT      3'h4
`define WSID_WDIV_UNC       3'h7
`define WSID_ZDIV_OFF       3'h6
`define WSID_TRUNC_MAX      5'h2
`define WSID_PBITS_BIAS     4'h2
`define WSID_BAL_HI         17'sh8
`define WSID_BAL_LO         17'sh0

`endif

// File: rtl/wsid_pkg.sv
/*
  Types of the weight stream index decoder.
  Assumes wsid_map.svh supplies the numeric constants.
*/
package wsid_pkg;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CHUNK,
    ST_WQ,
    ST_ZQ,
    ST_REM_SEL,
    ST_REM_FETCH,
    ST_REM_BITS,
    ST_MAP_WAIT,
    ST_OUT
  } wsid_state_e;

endpackage

// File: rtl/wsid_mem.sv
/*
  Small one-write one-read memory with registered read data.
  Assumes one clock; read data show the word addressed one cycle earlier.
*/
`timescale 1ns/1ns
module wsid_mem #(
  parameter int W  = 9,
  parameter int D  = 32,
  parameter int AW = 5
) (
  // Clock
  input  wire logic          core_clk_i,
  // Write side
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  // Read side
  input  wire logic [AW-1:0] raddr_i,
  output logic      [W-1:0]  rdata_o
);

  logic [W-1:0] mem_reg [D];

  // No reset on storage; contents are always written before being read
  always_ff @(posedge core_clk_i)
  begin
    if (we_i)
    begin
      mem_reg[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_reg[raddr_i];
  end

endmodule // wsid_mem

// File: rtl/wsid_fifo.sv
/*
  Output FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module wsid_fifo #(
  parameter int W = 17,
  parameter int D = 4
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_b_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);

  localparam int AW = $clog2(D);

  logic [W-1:0]  mem_reg [D];
  logic [AW:0]   wr_reg;
  logic [AW:0]   rd_reg;
  logic          full_w;
  logic          empty_w;
  logic          push_w;
  logic          pop_w;

  assign full_w      = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign empty_w     = (wr_reg == rd_reg);
  assign in_ready_o  = !full_w;
  assign out_valid_o = !empty_w;
  assign push_w      = in_valid_i && !full_w;
  assign pop_w       = out_ready_i && !empty_w;
  assign out_data_o  = mem_reg[rd_reg[AW-1:0]];

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      if (push_w)
      begin
        mem_reg[wr_reg[AW-1:0]] <= in_data_i;
        wr_reg                  <= wr_reg + 1'b1;
      end
      if (pop_w)
      begin
        rd_reg <= rd_reg + 1'b1;
      end
    end
  end

endmodule // wsid_fifo

// File: verification/wsid_far_model.sv
/*
  Far side of the decoder: a bit fetcher serving a loaded pattern and a
  weight consumer that can stall. Assumes one clock, drives at falling edges.
*/
`timescale 1ns/1ns
module wsid_far_model (
  // Clock
  input  wire logic        core_clk_i,
  // Bit stream
  output logic             bit_o,
  output logic             bit_valid_o,
  input  wire logic        bit_ready_i,
  // Items
  input  wire logic        out_valid_i,
  output logic             out_ready_o,
  input  wire logic        out_is_run_i,
  input  wire logic [15:0] out_value_i,
  // Control
  input  wire logic        stall_i,
  output logic             hold_err_o
);
  logic [63:0] pat;
  int          nbits;
  int          pos;
  logic [16:0] items [$];
  logic [16:0] held;
  logic        was_held;

  task automatic load(input logic [63:0] p, input int n);
    pat = p;
    nbits = n;
    pos = 0;
    items.delete();
  endtask

  initial
  begin
    {bit_o, bit_valid_o, out_ready_o, hold_err_o, was_held} = 5'h00;
    held = 17'h00000;
    nbits = 0;
    pos = 0;
  end

  // Spent stream shows flipped bits, never a stale copy
  always @(negedge core_clk_i)
  begin
    bit_valid_o <= pos < nbits;
    bit_o       <= (pos < nbits) ? pat[nbits-1-pos] : ~bit_o;
    out_ready_o <= !stall_i;
  end

  always @(posedge core_clk_i)
  begin
    if (bit_valid_o && bit_ready_i)
      pos++;
    if (out_valid_i && out_ready_o)
      items.push_back({out_is_run_i, out_value_i});
    if (was_held && out_valid_i && held !== {out_is_run_i, out_value_i})
      hold_err_o <= 1'b1;
    was_held <= out_valid_i && !out_ready_o;
    held     <= {out_is_run_i, out_value_i};
  end
endmodule // wsid_far_model

// File: verification/weight_stream_index_decoder_test.sv
/*
  Self-checking bench of the weight stream index decoder.
  Assumes wsid_far_model feeds bits and drains items.
*/
`timescale 1ns/1ns
module weight_stream_index_decoder_test;
  logic        core_clk, rst_b, slice_start, slice_ready;
  logic [14:0] slicelen;
  logic [2:0]  wdiv, zdiv, palbits;
  logic        wtrunc, newpal, pal_wr, bit_s, bit_valid, bit_ready;
  logic [4:0]  dirofs, palsize, pal_addr;
  logic [8:0]  pal_data;
  logic        out_valid, out_ready, out_is_run, stall, hold_err;
  logic [15:0] out_value;
  logic [16:0] exp_q [$];
  int          fail_count;
  int          compares;

  wsid_decoder DUT (.core_clk_i(core_clk), .rst_b_i(rst_b), .slice_start_i(slice_start),
    .slice_ready_o(slice_ready), .slicelen_i(slicelen), .wdiv_i(wdiv), .wtrunc_i(wtrunc),
    .newpal_i(newpal), .zdiv_i(zdiv), .dirofs_i(dirofs), .palsize_i(palsize),
    .palbits_i(palbits), .pal_wr_i(pal_wr), .pal_addr_i(pal_addr), .pal_data_i(pal_data),
    .bit_i(bit_s), .bit_valid_i(bit_valid), .bit_ready_o(bit_ready),
    .out_valid_o(out_valid), .out_ready_i(out_ready), .out_is_run_o(out_is_run),
    .out_value_o(out_value));

  wsid_far_model FAR (.core_clk_i(core_clk), .bit_o(bit_s), .bit_valid_o(bit_valid),
    .bit_ready_i(bit_ready), .out_valid_i(out_valid), .out_ready_o(out_ready),
    .out_is_run_i(out_is_run), .out_value_i(out_value), .stall_i(stall),
    .hold_err_o(hold_err));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic wait_idle(input int n);
    for (int i = 0; i < n && slice_ready !== 1'b1; i++)
      @(negedge core_clk);
    if (slice_ready !== 1'b1)
    begin
      check(1'b0, "decoder never went idle"); // Hang
      give_verdict();
    end
  endtask

  task automatic pal_write(input logic [4:0] a, input logic [8:0] d);
    {pal_wr, pal_addr, pal_data} = {1'b1, a, d};
    @(negedge core_clk);
    pal_wr = 1'b0;
    // Gap cycle so back-to-back writes never reassign the strobe in one step
    @(negedge core_clk);
  endtask

  task automatic set_hdr(input logic [14:0] sl, input logic [2:0] wd, input logic wt,
                         input logic np, input logic [2:0] zd, input logic [4:0] dof,
                         input logic [4:0] ps, input logic [2:0] pb);
    {slicelen, wdiv, wtrunc, newpal, zdiv, dirofs, palsize, palbits} =
      {sl, wd, wt, np, zd, dof, ps, pb};
  endtask

  // Header comes from set_hdr, expected items from exp_q
  task automatic run_slice(input logic [63:0] p, input int n, input logic hold);
    FAR.load(p, n);
    stall = hold;
    wait_idle(50);
    slice_start = 1'b1;
    @(negedge core_clk);
    slice_start = 1'b0;
    if (hold)
    begin
      repeat (200) @(negedge core_clk);
      check(FAR.pos < n && out_valid === 1'b1, "bits taken while output stalled"); // Halt
      stall = 1'b0;
    end
    repeat (2) @(negedge core_clk);
    wait_idle(2000);
    repeat (8) @(negedge core_clk);
    check(FAR.pos == n, "stream not consumed exactly"); // Chunks
    check(FAR.items.size() == exp_q.size(), "item count"); // Counts
    for (int i = 0; i < exp_q.size() && i < FAR.items.size(); i++)
      check(FAR.items[i] === exp_q[i], "item value"); // Values
    check(hold_err === 1'b0, "item changed while stalled"); // Stable
    exp_q.delete();
  endtask

  task automatic s_direct_rice();
    set_hdr(15'h0001, 3'h2, 1'b0, 1'b1, 3'h6, 5'h04, 5'h00, 3'h3); // First reload
    exp_q = '{17'h0fffc, 17'h0fffd};
    run_slice(64'h47, 7, 1'b0); // Rice direct
  endtask

  task automatic s_palette_unc();
    pal_write(5'h01, 9'h007);
    pal_write(5'h02, 9'h00a);
    pal_write(5'h00, 9'h004);
    set_hdr(15'h0001, 3'h7, 1'b0, 1'b1, 3'h6, 5'h00, 5'h03, 3'h0);
    exp_q = '{17'h0fffd, 17'h00005};
    run_slice(64'h6, 4, 1'b0); // Two-bit indices
  endtask

  // Junk header fields must be ignored without reload
  task automatic s_trunc_keep();
    set_hdr(15'h0002, 3'h0, 1'b1, 1'b0, 3'h6, 5'h1f, 5'h1f, 3'h7); // Same kind
    exp_q = '{17'h00005, 17'h0fffd, 17'h00002};
    run_slice(64'h1c, 5, 1'b0); // Truncated, quotients at most two
  endtask

  task automatic s_stall();
    set_hdr(15'h0007, 3'h1, 1'b0, 1'b1, 3'h6, 5'h02, 5'h00, 3'h3);
    for (int i = 0; i < 4; i++)
      exp_q.push_back(17'h00001);
    for (int i = 0; i < 4; i++)
      exp_q.insert(2 * i + 1, 17'h0ffff);
    run_slice(64'h0055, 16, 1'b1); // Back pressure
  endtask

  task automatic s_alternating();
    set_hdr(15'h0000, 3'h0, 1'b0, 1'b1, 3'h0, 5'h00, 5'h00, 3'h3);
    exp_q = '{17'h10002, 17'h00002, 17'h10000};
    run_slice(64'h1ec, 9, 1'b0); // Runs
    // No reload: weight first, run remainders of one bit, junk table fields
    set_hdr(15'h0000, 3'h1, 1'b0, 1'b0, 3'h1, 5'h1f, 5'h1f, 3'h7); // Kind kept
    exp_q = '{17'h0ffff, 17'h10005};
    run_slice(64'h5b, 7, 1'b0); // Run remainder
  endtask

  initial
  begin
    fail_count = 0;
    compares = 0;
    {rst_b, slice_start, pal_wr, stall} = 4'h0;
    set_hdr(15'h0000, 3'h0, 1'b0, 1'b0, 3'h6, 5'h00, 5'h00, 3'h0);
    pal_addr = 5'h00;
    pal_data = 9'h000;
    repeat (4) @(negedge core_clk);
    rst_b = 1'b1;
    check(slice_ready === 1'b1 && out_valid === 1'b0, "reset state"); // Reset
    s_direct_rice();
    s_palette_unc();
    s_trunc_keep();
    s_stall();
    s_alternating();
    give_verdict();
  end
endmodule // weight_stream_index_decoder_test
